// [shared/mec_defs.vh]
// Register offsets, field positions, reset values and timing scales of the motion-event register bank.
// Assumes an 8-bit register port and one sample strobe per output sample.
`ifndef MEC_DEFS_VH
`define MEC_DEFS_VH
`define MEC_ADDR_TAP_Y        8'h31
`define MEC_ADDR_TAP_Z        8'h32
`define MEC_ADDR_TAP_TIME     8'h33
`define MEC_ADDR_WAKE_THS     8'h34
`define MEC_ADDR_WAKE_TIME     8'h35
`define MEC_ADDR_FALL         8'h36
`define MEC_ADDR_EVENT_STATUS_MIRROR   8'h37
`define MEC_ADDR_WAKE_SRC     8'h38
`define MEC_ADDR_KNOCK_EVENT_SOURCE      8'h39
`define MEC_ADDR_ORIENT_SRC   8'h3a
`define MEC_RST_CFG           8'h00
`define MEC_POS_ORDER         5
`define MEC_POS_XEN           7
`define MEC_POS_YEN           6
`define MEC_POS_ZEN           5
`define MEC_POS_WINDOW        4
`define MEC_POS_QUIET         2
`define MEC_POS_PULSE         0
`define MEC_POS_TAPMODE       7
`define MEC_POS_SLEEPON       6
`define MEC_POS_FALLT5        7
`define MEC_POS_WAKET         5
`define MEC_POS_STATION       4
`define MEC_POS_FALLT         3
`define MEC_WINDOW_STEP       16'h0020
`define MEC_WINDOW_ZERO       16'h0010
`define MEC_QUIET_STEP        16'h0004
`define MEC_QUIET_ZERO        16'h0002
`define MEC_PULSE_STEP        16'h0008
`define MEC_PULSE_ZERO        16'h0004
`define MEC_SLEEP_STEP        16'h0200
`define MEC_SLEEP_ZERO        16'h0010
`endif

// [rtl/mec_time_decode.v]
// Converts the coded time fields into sample-period counts.
// Assumes the fields come straight from the configuration registers.
`timescale 1ns/1ps
`include "mec_defs.vh"
module mec_time_decode (
   // Coded fields
   input  wire [3:0]  window_code_in,
   input  wire [1:0]  quiet_code_in,
   input  wire [1:0]  pulse_code_in,
   input  wire [3:0]  sleep_code_in,
   // Counts in sample periods
   output wire [15:0] window_len_out,
   output wire [15:0] quiet_len_out,
   output wire [15:0] pulse_len_out,
   output wire [15:0] sleep_len_out
);
   assign window_len_out = (window_code_in == 4'h0) ? `MEC_WINDOW_ZERO :
                           ({12'h000, window_code_in} * `MEC_WINDOW_STEP); // [RULE_04]
   assign quiet_len_out  = (quiet_code_in == 2'h0) ? `MEC_QUIET_ZERO :
                           ({14'h0000, quiet_code_in} * `MEC_QUIET_STEP); // [RULE_05]
   assign pulse_len_out  = (pulse_code_in == 2'h0) ? `MEC_PULSE_ZERO :
                           ({14'h0000, pulse_code_in} * `MEC_PULSE_STEP); // [RULE_06]
   assign sleep_len_out  = (sleep_code_in == 4'h0) ? `MEC_SLEEP_ZERO :
                           ({12'h000, sleep_code_in} * `MEC_SLEEP_STEP); // [RULE_12]
endmodule // mec_time_decode

// [rtl/mec_motion_regs.v]
// Configuration and status register bank of the embedded motion-event engine.
// Assumes a simple byte register port from the serial interface and event pulses from the detectors.
`timescale 1ns/1ps
`include "mec_defs.vh"
// What this block does
// [RULE_01] Three-bit order code fixes tap axis priority, all eight codes decoded.
// [RULE_02] Each axis has a five-bit tap threshold a sample must exceed; here the X threshold is held at zero.
// [RULE_03] Per-axis enable bits include or exclude an axis from tap detection.
// [RULE_04] Double-tap window is code times 32 samples, code zero meaning 16.
// [RULE_05] Quiet time is code times 4 samples, code zero meaning 2.
// [RULE_06] Pulse length cap is code times 8 samples, code zero meaning 4.
// [RULE_07] Tap-mode bit allows double taps when set; resets to 0.
// [RULE_08] Inactivity-enable bit turns sleep detection on; resets to 0.
// [RULE_09] Wake threshold is six bits unsigned, 1/64 of scale, resets zero.
// [RULE_10] Two-bit wake duration counts in whole sample periods.
// [RULE_11] Stationary bit, reset 0, enables detection without rate change.
// [RULE_12] Sleep entry delay is code times 512 samples, code zero meaning 16.
// [RULE_13] Fall duration is six bits: top from wake register, low five from fall.
// [RULE_14] Fall threshold codes map to 5,7,8,10,11,13,15,16 LSB.
// [RULE_15] Overrun flag set only when FIFO full and a sample was overwritten.
// [RULE_16] Temperature-ready flag reads 1 when a new temperature result exists.
// [RULE_17] Acceleration-ready flag reads 1 only when all three axes are new.
// [RULE_18] Status mirror shows sleep, double, single, orientation and fall flags.
// [RULE_19] Wake source shows fall, sleep, wake and per-axis wake causes.
// [RULE_20] Tap source shows any, single, double tap and the sign bit.
// [RULE_21] Tap source shows which axis produced the tap.
// [RULE_22] Orientation source shows change flag and Z and Y high and low bits.
// [RULE_23] Orientation source also holds X high and X low bits.
// [RULE_24] Event capture and duration counters advance once per output sample.
module mec_motion_regs (
   // Clock and reset
   input  wire        ref_clk_in,
   input  wire        sys_rst_in,
   input  wire        clk_en_in,
   // Register port
   input  wire [7:0]  reg_addr_in,
   input  wire        reg_wr_in,
   input  wire        reg_rd_in,
   input  wire [7:0]  reg_wdata_in,
   output reg  [7:0]  reg_rdata_out,
   output reg         reg_rvalid_out,
   // Sample strobe and source flags
   input  wire        sample_tick_in,
   input  wire        fifo_full_in,
   input  wire        fifo_overwrite_in,
   input  wire        temp_done_in,
   input  wire [2:0]  axis_new_in,
   input  wire        inactivity_event_in,
   input  wire        single_knock_in,
   input  wire        double_knock_in,
   input  wire        orientation_change_event_in,
   input  wire        fall_event_in,
   input  wire        wake_event_in,
   input  wire [2:0]  wake_axis_in,
   input  wire        knock_sign_in,
   input  wire [2:0]  knock_axis_in,
   input  wire [5:0]  orient_over_in,
   // Decoded configuration to the detectors
   output reg  [8:0]  knock_order_out,
   output reg  [14:0] knock_level_out,
   output reg  [2:0]  knock_axis_en_out,
   output reg  [15:0] double_knock_window_out,
   output reg  [15:0] quiet_len_out,
   output reg  [15:0] pulse_len_out,
   output reg         double_knock_en_out,
   output reg         inactivity_en_out,
   output reg  [5:0]  wake_level_out,
   output reg  [1:0]  wake_time_out,
   output reg         stationary_en_out,
   output reg  [15:0] inactivity_entry_len_out,
   output reg  [5:0]  fall_time_out,
   output reg  [4:0]  fall_level_out,
   // Duration counter
   output reg  [15:0] sample_count_out
);
   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   reg  [7:0]  tap_y_q;
   reg  [7:0]  tap_z_q;
   reg  [7:0]  tap_time_q;
   reg  [7:0]  wake_ths_q;
   reg  [7:0]  wake_time_q;
   reg  [7:0]  fall_q;
   reg  [7:0]  tap_x_lvl_q;
   wire        wr_en;
   wire        rd_en;
   wire        tick;
   wire [15:0] window_len;
   wire [15:0] quiet_len;
   wire [15:0] pulse_len;
   wire [15:0] sleep_len;

   assign wr_en = clk_en_in & reg_wr_in;
   assign rd_en = clk_en_in & reg_rd_in;
   assign tick  = clk_en_in & sample_tick_in;

   // The X threshold sits outside this bank, so it is held at zero here.
   always @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         tap_y_q     <= `MEC_RST_CFG;
         tap_z_q     <= `MEC_RST_CFG;
         tap_time_q  <= `MEC_RST_CFG;
         wake_ths_q  <= `MEC_RST_CFG;
         wake_time_q  <= `MEC_RST_CFG;
         fall_q      <= `MEC_RST_CFG;
         tap_x_lvl_q <= `MEC_RST_CFG;
      end else if (wr_en) begin
         case (reg_addr_in)
            `MEC_ADDR_TAP_Y:    tap_y_q    <= reg_wdata_in;
            `MEC_ADDR_TAP_Z:    tap_z_q    <= reg_wdata_in;
            `MEC_ADDR_TAP_TIME: tap_time_q <= reg_wdata_in;
            `MEC_ADDR_WAKE_THS: wake_ths_q <= reg_wdata_in; // [RULE_09]
            `MEC_ADDR_WAKE_TIME: wake_time_q <= reg_wdata_in;
            `MEC_ADDR_FALL:     fall_q     <= reg_wdata_in;
            default:            tap_x_lvl_q <= tap_x_lvl_q;
         endcase
      end
   end

   mec_time_decode u_time (
      .window_code_in (tap_time_q[`MEC_POS_WINDOW +: 4]),
      .quiet_code_in  (tap_time_q[`MEC_POS_QUIET +: 2]),
      .pulse_code_in  (tap_time_q[`MEC_POS_PULSE +: 2]),
      .sleep_code_in  (wake_time_q[3:0]),
      .window_len_out (window_len),
      .quiet_len_out  (quiet_len),
      .pulse_len_out  (pulse_len),
      .sleep_len_out  (sleep_len)
   );

   // ----------------------------------------------------------------
   // Decoders
   // ----------------------------------------------------------------
   // Order is packed max, mid, min; each axis code is 0 X, 1 Y, 2 Z.
   function [8:0] order_decode;
      input [2:0] code;
      begin
         case (code)
            3'h0:    order_decode = {3'h0, 3'h1, 3'h2};
            3'h1:    order_decode = {3'h1, 3'h0, 3'h2};
            3'h2:    order_decode = {3'h0, 3'h2, 3'h1};
            3'h3:    order_decode = {3'h2, 3'h1, 3'h0};
            3'h4:    order_decode = {3'h0, 3'h1, 3'h2};
            3'h5:    order_decode = {3'h1, 3'h2, 3'h0};
            3'h6:    order_decode = {3'h2, 3'h0, 3'h1};
            default: order_decode = {3'h2, 3'h1, 3'h0};
         endcase
      end
   endfunction

   function [4:0] fall_decode;
      input [2:0] code;
      begin
         case (code)
            3'h0:    fall_decode = 5'h05;
            3'h1:    fall_decode = 5'h07;
            3'h2:    fall_decode = 5'h08;
            3'h3:    fall_decode = 5'h0a;
            3'h4:    fall_decode = 5'h0b;
            3'h5:    fall_decode = 5'h0d;
            3'h6:    fall_decode = 5'h0f;
            default: fall_decode = 5'h10;
         endcase
      end
   endfunction

   // Registered so every detector sees a glitch-free copy of its setting.
   always @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         knock_order_out          <= 9'h00a;
         knock_level_out          <= 15'h0000;
         knock_axis_en_out        <= 3'h0;
         double_knock_window_out  <= `MEC_WINDOW_ZERO;
         quiet_len_out            <= `MEC_QUIET_ZERO;
         pulse_len_out            <= `MEC_PULSE_ZERO;
         double_knock_en_out      <= 1'b0;
         inactivity_en_out        <= 1'b0;
         wake_level_out           <= 6'h00;
         wake_time_out            <= 2'h0;
         stationary_en_out        <= 1'b0;
         inactivity_entry_len_out <= `MEC_SLEEP_ZERO;
         fall_time_out            <= 6'h00;
         fall_level_out           <= 5'h05;
      end else if (clk_en_in) begin
         knock_order_out          <= order_decode(tap_y_q[`MEC_POS_ORDER +: 3]); // [RULE_01]
         knock_level_out          <= {tap_z_q[4:0], tap_y_q[4:0], tap_x_lvl_q[4:0]}; // [RULE_02]
         knock_axis_en_out        <= {tap_z_q[`MEC_POS_ZEN], tap_z_q[`MEC_POS_YEN],
                                      tap_z_q[`MEC_POS_XEN]}; // [RULE_03]
         double_knock_window_out  <= window_len; // [RULE_04]
         quiet_len_out            <= quiet_len; // [RULE_05]
         pulse_len_out            <= pulse_len; // [RULE_06]
         double_knock_en_out      <= wake_ths_q[`MEC_POS_TAPMODE]; // [RULE_07]
         inactivity_en_out        <= wake_ths_q[`MEC_POS_SLEEPON]; // [RULE_08]
         wake_level_out           <= wake_ths_q[5:0]; // [RULE_09]
         wake_time_out            <= wake_time_q[`MEC_POS_WAKET +: 2]; // [RULE_10]
         stationary_en_out        <= wake_time_q[`MEC_POS_STATION]; // [RULE_11]
         inactivity_entry_len_out <= sleep_len; // [RULE_12]
         fall_time_out            <= {wake_time_q[`MEC_POS_FALLT5], fall_q[`MEC_POS_FALLT +: 5]}; // [RULE_13]
         fall_level_out           <= fall_decode(fall_q[2:0]); // [RULE_14]
      end
   end

   // ----------------------------------------------------------------
   // Status capture, once per sample
   // ----------------------------------------------------------------
   // Flags show the detector state of the last sample; clearing on read is done elsewhere.
   reg  [7:0]  status_q;
   reg  [5:0]  wake_src_q;
   reg  [6:0]  knock_event_source_q;
   reg  [6:0]  orient_q;
   reg         temp_pend_q;
   reg  [2:0]  axis_pend_q;
   wire [2:0]  axis_all;

   assign axis_all = axis_pend_q | axis_new_in;

   always @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         status_q         <= 8'h00;
         wake_src_q       <= 6'h00;
         knock_event_source_q        <= 7'h00;
         orient_q         <= 7'h00;
         temp_pend_q      <= 1'b0;
         axis_pend_q      <= 3'h0;
         sample_count_out <= 16'h0000;
      end else if (clk_en_in) begin
         // Arrivals between ticks are held so a ready edge is never missed.
         temp_pend_q <= tick ? 1'b0 : (temp_pend_q | temp_done_in);
         axis_pend_q <= tick ? 3'h0 : axis_all;
         if (tick) begin
            sample_count_out <= sample_count_out + 16'h0001; // [RULE_24]
            status_q[7] <= fifo_full_in & fifo_overwrite_in; // [RULE_15]
            status_q[6] <= temp_pend_q | temp_done_in; // [RULE_16]
            status_q[5] <= inactivity_event_in; // [RULE_18]
            status_q[4] <= double_knock_in; // [RULE_18]
            status_q[3] <= single_knock_in; // [RULE_18]
            status_q[2] <= orientation_change_event_in; // [RULE_18]
            status_q[1] <= fall_event_in; // [RULE_18]
            status_q[0] <= &axis_all; // [RULE_17]
            wake_src_q  <= {fall_event_in, inactivity_event_in, wake_event_in, wake_axis_in}; // [RULE_19]
            knock_event_source_q   <= {single_knock_in | double_knock_in, single_knock_in, double_knock_in,
                            knock_sign_in, knock_axis_in}; // [RULE_20] [RULE_21]
            orient_q    <= {orientation_change_event_in, orient_over_in}; // [RULE_22] [RULE_23]
         end
      end
   end

   // ----------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------
   // Unmapped addresses read as zero; reads have no side effects here.
   always @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         reg_rdata_out  <= 8'h00;
         reg_rvalid_out <= 1'b0;
      end else if (clk_en_in) begin
         reg_rvalid_out <= rd_en;
         if (rd_en) begin
            case (reg_addr_in)
               `MEC_ADDR_TAP_Y:      reg_rdata_out <= tap_y_q;
               `MEC_ADDR_TAP_Z:      reg_rdata_out <= tap_z_q;
               `MEC_ADDR_TAP_TIME:   reg_rdata_out <= tap_time_q;
               `MEC_ADDR_WAKE_THS:   reg_rdata_out <= wake_ths_q;
               `MEC_ADDR_WAKE_TIME:   reg_rdata_out <= wake_time_q;
               `MEC_ADDR_FALL:       reg_rdata_out <= fall_q;
               `MEC_ADDR_EVENT_STATUS_MIRROR: reg_rdata_out <= status_q; // [RULE_18]
               `MEC_ADDR_WAKE_SRC:   reg_rdata_out <= {2'h0, wake_src_q}; // [RULE_19]
               `MEC_ADDR_KNOCK_EVENT_SOURCE:    reg_rdata_out <= {1'b0, knock_event_source_q}; // [RULE_20]
               `MEC_ADDR_ORIENT_SRC: reg_rdata_out <= {1'b0, orient_q}; // [RULE_22]
               default:              reg_rdata_out <= 8'h00;
            endcase
         end
      end
   end
endmodule // mec_motion_regs

// [testbench/mec_regs_chk.sv]
// Port checker for the motion-event register bank.
// Assumes decoded outputs settle one enabled edge after a taken write.
`timescale 1ns/1ps
module mec_regs_chk (
   // Clock, reset and register port
   input wire        ref_clk_in, sys_rst_in, clk_en_in, reg_wr_in, reg_rd_in, reg_rvalid_out, sample_tick_in,
   input wire [7:0]  reg_addr_in, reg_wdata_in,
   // Decoded configuration and counter
   input wire [8:0]  knock_order_out,
   input wire [14:0] knock_level_out,
   input wire [2:0]  knock_axis_en_out,
   input wire [15:0] double_knock_window_out, quiet_len_out, pulse_len_out, inactivity_entry_len_out,
   input wire [15:0] sample_count_out,
   input wire        double_knock_en_out, inactivity_en_out, stationary_en_out,
   input wire [5:0]  wake_level_out, fall_time_out,
   input wire [1:0]  wake_time_out,
   input wire [4:0]  fall_level_out
);
   localparam [71:0] ORD = {9'h088, 9'h081, 9'h050, 9'h00a, 9'h088, 9'h011, 9'h042, 9'h00a};
   localparam [39:0] FLV = {5'h10, 5'h0f, 5'h0d, 5'h0b, 5'h0a, 5'h08, 5'h07, 5'h05};
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (sys_rst_in);
   function automatic [15:0] scl(input [3:0] c, input [15:0] z, input [15:0] s);
      scl = (c == 4'h0) ? z : c * s;
   endfunction
   // A write only counts when the decode edge after it is enabled too.
   property p_order;
      logic [7:0] d;
      (reg_wr_in && clk_en_in && reg_addr_in == 8'h31, d = reg_wdata_in) ##1 clk_en_in |=>
         knock_order_out == ORD[d[7:5]*9 +: 9] && knock_level_out[9:5] == d[4:0];
   endproperty
   a_order: assert property (p_order) else $error("order or y level wrong");
   property p_zcfg;
      logic [7:0] d;
      (reg_wr_in && clk_en_in && reg_addr_in == 8'h32, d = reg_wdata_in) ##1 clk_en_in |=>
         knock_axis_en_out == {d[5], d[6], d[7]} && knock_level_out == {d[4:0], knock_level_out[9:5], 5'h00};
   endproperty
   a_zcfg: assert property (p_zcfg) else $error("axis enable or z level wrong");
   property p_timing;
      logic [7:0] d;
      (reg_wr_in && clk_en_in && reg_addr_in == 8'h33, d = reg_wdata_in) ##1 clk_en_in |=>
         double_knock_window_out == scl(d[7:4], 16'h0010, 16'h0020) && quiet_len_out == scl(d[3:2], 16'h0002,
         16'h0004) && pulse_len_out == scl(d[1:0], 16'h0004, 16'h0008);
   endproperty
   a_timing: assert property (p_timing) else $error("tap timing wrong");
   property p_wake;
      logic [7:0] d;
      (reg_wr_in && clk_en_in && reg_addr_in == 8'h34, d = reg_wdata_in) ##1 clk_en_in |=>
         {double_knock_en_out, inactivity_en_out, wake_level_out} == d;
   endproperty
   a_wake: assert property (p_wake) else $error("wake config wrong");
   property p_dur;
      logic [7:0] d;
      (reg_wr_in && clk_en_in && reg_addr_in == 8'h35, d = reg_wdata_in) ##1 clk_en_in |=>
         {fall_time_out[5], wake_time_out, stationary_en_out} == d[7:4] &&
         inactivity_entry_len_out == scl(d[3:0], 16'h0010, 16'h0200);
   endproperty
   a_dur: assert property (p_dur) else $error("durations wrong");
   property p_fall;
      logic [7:0] d;
      (reg_wr_in && clk_en_in && reg_addr_in == 8'h36, d = reg_wdata_in) ##1 clk_en_in |=>
         fall_time_out[4:0] == d[7:3] && fall_level_out == FLV[d[2:0]*5 +: 5];
   endproperty
   a_fall: assert property (p_fall) else $error("fall config wrong");
   property p_rd;
      reg_rd_in && clk_en_in |=> reg_rvalid_out;
   endproperty
   a_rd: assert property (p_rd) else $error("read not answered");
   property p_count;
      sample_tick_in && clk_en_in |=> sample_count_out == $past(sample_count_out) + 16'h0001;
   endproperty
   a_count: assert property (p_count) else $error("tick not counted");
   property p_freeze;
      !clk_en_in |=> $stable(sample_count_out);
   endproperty
   a_freeze: assert property (p_freeze) else $error("count moved while frozen");
   c_tick: cover property (sample_tick_in && clk_en_in);
   c_read: cover property (reg_rd_in && reg_addr_in == 8'h37 ##1 reg_rvalid_out);
   c_wr: cover property (reg_wr_in && reg_addr_in == 8'h33);
endmodule // mec_regs_chk
bind mec_motion_regs mec_regs_chk chk_u (.ref_clk_in, .sys_rst_in, .clk_en_in, .reg_wr_in, .reg_rd_in,
   .reg_rvalid_out, .sample_tick_in, .reg_addr_in, .reg_wdata_in, .knock_order_out, .knock_level_out,
   .knock_axis_en_out, .double_knock_window_out, .quiet_len_out, .pulse_len_out, .inactivity_entry_len_out,
   .sample_count_out, .double_knock_en_out, .inactivity_en_out, .stationary_en_out, .wake_level_out,
   .fall_time_out, .wake_time_out, .fall_level_out);

// [testbench/mec_event_src.sv]
// Stand-in for the motion detectors feeding the register bank.
// Assumes one request per sample; levels hold until the next request.
`timescale 1ns/1ps
module mec_event_src (
   input  wire        ref_clk_in,
   input  wire        sys_rst_in,
   input  wire        go_in,
   input  wire [24:0] pat_in,
   output reg         tick_out,
   output reg  [24:0] ev_out
);
   reg pend_q;
   // The strobe trails the levels by a cycle so they are settled when sampled.
   always @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         tick_out <= 1'b0;
         ev_out   <= 25'h0;
         pend_q   <= 1'b0;
      end else begin
         tick_out <= pend_q;
         pend_q   <= go_in;
         if (go_in) begin
            ev_out <= pat_in;
         end
      end
   end
endmodule // mec_event_src

// [testbench/mec_motion_regs_tb.sv]
// Self-checking bench for the motion-event register bank.
// Assumes reads answer one edge after the request and writes decode one edge after storage.
`timescale 1ns/1ps
module mec_motion_regs_tb;
   localparam [71:0] ORD_T = {9'h088, 9'h081, 9'h050, 9'h00a, 9'h088, 9'h011, 9'h042, 9'h00a};
   localparam [39:0] FL_T  = {5'h10, 5'h0f, 5'h0d, 5'h0b, 5'h0a, 5'h08, 5'h07, 5'h05};
   localparam [23:0] CFG   = {8'h5a, 8'hff, 8'h00};
   reg         clk, rst, clk_en, wr, rd, go;
   reg  [7:0]  addr, wdata, d;
   reg  [24:0] pat;
   wire [24:0] ev;
   wire        tick, rvalid, dk_en, in_en, st_en;
   wire [7:0]  rdata;
   wire [8:0]  order;
   wire [14:0] level;
   wire [2:0]  axis_en;
   wire [15:0] win, quiet, pulse, sleep, cnt;
   wire [5:0]  wk_lvl, f_time;
   wire [1:0]  wk_time;
   wire [4:0]  f_lvl;
   integer     n_errors, cmp_count, k;
   mec_motion_regs dut_u (.ref_clk_in(clk), .sys_rst_in(rst), .clk_en_in(clk_en), .reg_addr_in(addr),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
      .sample_tick_in(tick), .fifo_full_in(ev[24]), .fifo_overwrite_in(ev[23]), .temp_done_in(ev[22]),
      .axis_new_in(ev[21:19]), .inactivity_event_in(ev[18]), .single_knock_in(ev[17]), .double_knock_in(ev[16]),
      .orientation_change_event_in(ev[15]), .fall_event_in(ev[14]), .wake_event_in(ev[13]),
      .wake_axis_in(ev[12:10]), .knock_sign_in(ev[9]), .knock_axis_in(ev[8:6]), .orient_over_in(ev[5:0]),
      .knock_order_out(order), .knock_level_out(level), .knock_axis_en_out(axis_en), .double_knock_window_out(win),
      .quiet_len_out(quiet), .pulse_len_out(pulse), .double_knock_en_out(dk_en), .inactivity_en_out(in_en),
      .wake_level_out(wk_lvl), .wake_time_out(wk_time), .stationary_en_out(st_en),
      .inactivity_entry_len_out(sleep), .fall_time_out(f_time), .fall_level_out(f_lvl), .sample_count_out(cnt));
   mec_event_src src_u (.ref_clk_in(clk), .sys_rst_in(rst), .go_in(go), .pat_in(pat), .tick_out(tick), .ev_out(ev));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // ----
   // Access and check tasks
   // ----
   task chk(input [15:0] got, input [15:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
         end
      end
   endtask
   task finish_test;
      begin
         $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
         if (n_errors == 0 && cmp_count > 0) begin
            $display("Regression OK");
         end else begin
            $display("Regression broken");
         end
         $finish;
      end
   endtask
   task wr_reg(input [7:0] a, input [7:0] v);
      begin
         @(posedge clk);
         addr  <= a;
         wdata <= v;
         wr    <= 1'b1;
         @(posedge clk);
         wr <= 1'b0;
      end
   endtask
   task rd_reg(input [7:0] a, input [7:0] exp);
      integer t;
      begin
         @(posedge clk);
         addr <= a;
         rd   <= 1'b1;
         @(posedge clk);
         rd <= 1'b0;
         #1;
         t = 0;
         while (rvalid !== 1'b1 && t < 4) begin
            @(posedge clk);
            #1;
            t = t + 1;
         end
         if (t == 4) begin
            n_errors = n_errors + 1;
            $display("unexpected at %0t: no read answer", $time);
            finish_test;
         end else begin
            chk({8'h00, rdata}, {8'h00, exp});
         end
      end
   endtask
   task settle;
      begin
         @(posedge clk);
         #1;
      end
   endtask
   task fire(input [24:0] p);
      begin
         @(posedge clk);
         pat <= p;
         go  <= 1'b1;
         @(posedge clk);
         go <= 1'b0;
         repeat (3) @(posedge clk);
      end
   endtask
   initial begin
      n_errors = 0;
      cmp_count = 0;
      {rst, clk_en, wr, rd, go, addr, wdata, pat} = {2'b11, 3'b000, 16'h0000, 25'h0};
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      for (k = 8'h31; k <= 8'h36; k = k + 1) rd_reg(k[7:0], 8'h00);
      chk(order, 16'h000a);
      chk(win, 16'h0010);
      chk(quiet, 16'h0002);
      chk(pulse, 16'h0004);
      chk(sleep, 16'h0010);
      chk({dk_en, in_en, st_en, wk_lvl, f_lvl}, {9'h000, 5'h05});
      $display("test reset finished");
      for (k = 0; k < 8; k = k + 1) begin
         d = {k[2:0], ~k[4:0]};
         wr_reg(8'h31, d);
         settle;
         chk({order, level[9:5]}, {ORD_T[k*9 +: 9], d[4:0]});
         d = {~k[4:0], k[2:0]};
         wr_reg(8'h36, d);
         settle;
         chk({f_lvl, f_time[4:0]}, {FL_T[k*5 +: 5], d[7:3]});
      end
      rd_reg(8'h36, 8'hc7);
      $display("test codes finished");
      for (k = 0; k < 3; k = k + 1) begin
         d = CFG[k*8 +: 8];
         for (int a = 8'h32; a <= 8'h35; a++) wr_reg(a[7:0], d);
         settle;
         chk({axis_en, level[14:10], level[4:0]}, {d[5], d[6], d[7], d[4:0], 5'h00});
         chk(win, (d[7:4] == 4'h0) ? 16'h0010 : d[7:4] * 16'h0020);
         chk(quiet, (d[3:2] == 2'h0) ? 16'h0002 : d[3:2] * 16'h0004);
         chk(pulse, (d[1:0] == 2'h0) ? 16'h0004 : d[1:0] * 16'h0008);
         chk({dk_en, in_en, wk_lvl}, d);
         chk({f_time[5], wk_time, st_en}, d[7:4]);
         chk(sleep, (d[3:0] == 4'h0) ? 16'h0010 : d[3:0] * 16'h0200);
         rd_reg(8'h35, d);
      end
      $display("test config finished");
      wr_reg(8'h38, 8'hff);
      rd_reg(8'h38, 8'h00);
      rd_reg(8'h3b, 8'h00);
      @(posedge clk);
      clk_en <= 1'b0;
      wr_reg(8'h31, 8'h00);
      @(posedge clk);
      clk_en <= 1'b1;
      rd_reg(8'h31, 8'hf8);
      $display("test refusals finished");
      fire(25'h1ffffff);
      rd_reg(8'h37, 8'hff);
      rd_reg(8'h38, 8'h3f);
      rd_reg(8'h39, 8'h7f);
      rd_reg(8'h3a, 8'h7f);
      // The held all-ones levels keep arriving, so one quiet sample drains them first.
      fire(25'h0000000);
      fire({3'h4, 3'h3, 4'h4, 2'h1, 3'h2, 1'b0, 3'h4, 6'h01});
      rd_reg(8'h37, 8'h08);
      rd_reg(8'h38, 8'h0a);
      rd_reg(8'h39, 8'h64);
      rd_reg(8'h3a, 8'h01);
      chk(cnt, 16'h0003);
      $display("test status finished");
      finish_test;
   end
endmodule // mec_motion_regs_tb
